/* rtl/dctr_top.sv */
// Two 24-bit countdown timer channels with register port and interrupt
// Assumes one 100 MHz clock; strobes one cycle, never both at once
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/100ps

module dctr_top (
    input  wire logic        REF_CLK,
    input  wire logic        RST_N,
    input  wire logic [7:0]  ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [31:0] RDATA,
    output logic             IRQ
);

    typedef struct packed {
        logic [1:0][23:0] reload;
        logic [1:0][23:0] count;
        logic [1:0][2:0]  ctrl;
        logic [1:0]       flag;
        logic [1:0]       stat;
        logic [1:0]       mask;
        logic [4:0]       div;
        logic [31:0]      rdata;
        logic             irq;
    } dctr_state_type;

    dctr_state_type st_r;
    dctr_state_type st_nxt;

    ////////////////////////////////////////////////////////////////////
    // Register decode
    logic [1:0] wr_reload;
    logic [1:0] wr_ctrl;
    logic [1:0] rd_eoi;
    logic       tick;
    logic [1:0] hit_zero;

    always_comb begin
        wr_reload[0] = WR && ADDR == dctr_pkg::CH2_RELOAD;
        wr_reload[1] = WR && ADDR == dctr_pkg::CH3_RELOAD;
        wr_ctrl[0]   = WR && ADDR == dctr_pkg::CH2_CTRL;
        wr_ctrl[1]   = WR && ADDR == dctr_pkg::CH3_CTRL;
        rd_eoi[0]    = RD && ADDR == dctr_pkg::CH2_EOI;
        rd_eoi[1]    = RD && ADDR == dctr_pkg::CH3_EOI;
        tick         = st_r.div == dctr_pkg::TICK_LAST;
    end

    ////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        st_nxt = st_r;
        st_nxt.div = tick ? 5'h00 : 5'(st_r.div + 5'h01);
        for (int i = 0; i < dctr_pkg::NCH; i++) begin
            hit_zero[i] = tick && st_r.ctrl[i][dctr_pkg::CTL_EN]
                          && st_r.count[i] == dctr_pkg::CNT_RST;
            if (wr_reload[i]) begin
                st_nxt.reload[i] = WDATA[23:0];
            end
            if (wr_ctrl[i]) begin
                st_nxt.ctrl[i] = WDATA[2:0];
            end
            // Enable edge loads first so no stale count escapes
            if (wr_ctrl[i] && WDATA[dctr_pkg::CTL_EN]
                && !st_r.ctrl[i][dctr_pkg::CTL_EN]) begin
                st_nxt.count[i] = st_r.reload[i];
            end else if (hit_zero[i]) begin
                st_nxt.count[i] = st_r.ctrl[i][dctr_pkg::CTL_MODE]
                    ? st_r.reload[i] : dctr_pkg::CNT_MAX;
            end else if (tick && st_r.ctrl[i][dctr_pkg::CTL_EN]) begin
                st_nxt.count[i] = st_r.count[i] - 24'h000001;
            end
            // Set wins over a clear in the same cycle
            if (rd_eoi[i]) begin
                st_nxt.flag[i] = 1'b0;
            end
            if (hit_zero[i] && !st_r.ctrl[i][dctr_pkg::CTL_MSK]) begin
                st_nxt.flag[i] = 1'b1;
            end
            if (WR && ADDR == dctr_pkg::IRQ_STAT && WDATA[i]) begin
                st_nxt.stat[i] = 1'b0;
            end
            if (hit_zero[i] && !st_r.ctrl[i][dctr_pkg::CTL_MSK]) begin
                st_nxt.stat[i] = 1'b1;
            end
        end
        if (WR && ADDR == dctr_pkg::IRQ_MASK) begin
            st_nxt.mask = WDATA[1:0];
        end
        st_nxt.irq = |(st_nxt.stat & st_nxt.mask);
        // Read data valid the cycle after the strobe only
        st_nxt.rdata = 32'h00000000;
        if (RD) begin
            case (ADDR)
                dctr_pkg::CH2_RELOAD: st_nxt.rdata = {8'h00, st_r.reload[0]};
                dctr_pkg::CH2_LIVE:   st_nxt.rdata = {8'h00, st_r.count[0]};
                dctr_pkg::CH2_CTRL:   st_nxt.rdata = {29'h0, st_r.ctrl[0]};
                dctr_pkg::CH2_FLAG:   st_nxt.rdata = {31'h0, st_r.flag[0]};
                dctr_pkg::CH3_RELOAD: st_nxt.rdata = {8'h00, st_r.reload[1]};
                dctr_pkg::CH3_LIVE:   st_nxt.rdata = {8'h00, st_r.count[1]};
                dctr_pkg::CH3_CTRL:   st_nxt.rdata = {29'h0, st_r.ctrl[1]};
                dctr_pkg::CH3_FLAG:   st_nxt.rdata = {31'h0, st_r.flag[1]};
                dctr_pkg::IRQ_STAT:   st_nxt.rdata = {30'h0, st_r.stat};
                dctr_pkg::IRQ_MASK:   st_nxt.rdata = {30'h0, st_r.mask};
                default:              st_nxt.rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_N) begin
        if (!RST_N) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign RDATA = st_r.rdata;
    assign IRQ   = st_r.irq;

    ////////////////////////////////////////////////////////////////////
    // Checks
    sequence s_arm2;
        WR && ADDR == dctr_pkg::CH2_CTRL && WDATA[dctr_pkg::CTL_EN]
        && !st_r.ctrl[0][dctr_pkg::CTL_EN];
    endsequence

    sequence s_arm3;
        WR && ADDR == dctr_pkg::CH3_CTRL && WDATA[dctr_pkg::CTL_EN]
        && !st_r.ctrl[1][dctr_pkg::CTL_EN];
    endsequence

    sequence s_quiet8;
        (!tick) [*8];
    endsequence

    // Tick period is exactly the divider length
    sequence s_tick_gap;
        s_quiet8 ##1 s_quiet8 ##1 s_quiet8 ##1 tick;
    endsequence

    sequence s_run2;
        tick && st_r.ctrl[0][dctr_pkg::CTL_EN] && !hit_zero[0] && !wr_ctrl[0];
    endsequence

    sequence s_run3;
        tick && st_r.ctrl[1][dctr_pkg::CTL_EN] && !hit_zero[1] && !wr_ctrl[1];
    endsequence

    sequence s_wrap2;
        hit_zero[0] && !wr_ctrl[0];
    endsequence

    sequence s_wrap3;
        hit_zero[1] && !wr_ctrl[1];
    endsequence

    a_enable_load: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        s_arm2 |=> st_r.count[0] == $past(st_r.reload[0]))
        else $error("enable did not load reload value");

    a_enable_load3: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        s_arm3 |=> st_r.count[1] == $past(st_r.reload[1]))
        else $error("channel three enable did not load");

    a_run_dec2: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        s_run2 |=> st_r.count[0] == $past(st_r.count[0]) - 24'h000001)
        else $error("channel two did not decrement");

    a_run_dec3: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        s_run3 |=> st_r.count[1] == $past(st_r.count[1]) - 24'h000001)
        else $error("channel three did not decrement");

    a_user_reload2: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        s_wrap2 ##0 st_r.ctrl[0][dctr_pkg::CTL_MODE]
        |=> st_r.count[0] == $past(st_r.reload[0]))
        else $error("user mode did not reload");

    a_user_reload3: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        s_wrap3 ##0 st_r.ctrl[1][dctr_pkg::CTL_MODE]
        |=> st_r.count[1] == $past(st_r.reload[1]))
        else $error("channel three user mode did not reload");

    a_free_wrap2: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        s_wrap2 ##0 !st_r.ctrl[0][dctr_pkg::CTL_MODE]
        |=> st_r.count[0] == dctr_pkg::CNT_MAX)
        else $error("channel two free mode did not wrap");

    a_free_wrap: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        s_wrap3 ##0 !st_r.ctrl[1][dctr_pkg::CTL_MODE]
        |=> st_r.count[1] == dctr_pkg::CNT_MAX)
        else $error("free mode did not wrap to max");

    a_disabled_hold2: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        !st_r.ctrl[0][dctr_pkg::CTL_EN] && !wr_ctrl[0]
        |=> $stable(st_r.count[0]))
        else $error("disabled channel two counted");

    a_disabled_hold: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        !st_r.ctrl[1][dctr_pkg::CTL_EN] && !wr_ctrl[1]
        |=> $stable(st_r.count[1]))
        else $error("disabled channel counted");

    a_idle_hold2: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        !tick && !wr_ctrl[0] |=> $stable(st_r.count[0]))
        else $error("channel two moved between ticks");

    a_idle_hold3: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        !tick && !wr_ctrl[1] |=> $stable(st_r.count[1]))
        else $error("channel three moved between ticks");

    a_live_ro: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        WR && ADDR == dctr_pkg::CH2_LIVE && !tick |=> $stable(st_r.count[0]))
        else $error("live count changed on write");

    a_live3_ro: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        WR && ADDR == dctr_pkg::CH3_LIVE && !tick |=> $stable(st_r.count[1]))
        else $error("channel three live count changed on write");

    a_reload2_wr: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        wr_reload[0] |=> st_r.reload[0] == $past(WDATA[23:0]))
        else $error("channel two reload not stored");

    a_reload_wr: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        wr_reload[1] |=> st_r.reload[1] == $past(WDATA[23:0]))
        else $error("reload not stored");

    a_reload_keep2: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        !wr_reload[0] |=> $stable(st_r.reload[0]))
        else $error("channel two reload changed unasked");

    a_reload_keep3: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        !wr_reload[1] |=> $stable(st_r.reload[1]))
        else $error("channel three reload changed unasked");

    a_ctrl_wr2: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        wr_ctrl[0] |=> st_r.ctrl[0] == $past(WDATA[dctr_pkg::CTL_W-1:0]))
        else $error("channel two control not stored");

    a_ctrl_wr3: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        wr_ctrl[1] |=> st_r.ctrl[1] == $past(WDATA[dctr_pkg::CTL_W-1:0]))
        else $error("channel three control not stored");

    a_flag_set: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        hit_zero[0] && !st_r.ctrl[0][dctr_pkg::CTL_MSK] |=> st_r.flag[0])
        else $error("zero did not set flag");

    a_flag3_set: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        hit_zero[1] && !st_r.ctrl[1][dctr_pkg::CTL_MSK] |=> st_r.flag[1])
        else $error("channel three zero did not set flag");

    a_mask_hold: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        hit_zero[0] && st_r.ctrl[0][dctr_pkg::CTL_MSK] && !st_r.flag[0]
        |=> !st_r.flag[0])
        else $error("masked channel raised flag");

    a_mask3_hold: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        hit_zero[1] && st_r.ctrl[1][dctr_pkg::CTL_MSK] && !st_r.flag[1]
        |=> !st_r.flag[1])
        else $error("masked channel three raised flag");

    a_eoi_clear: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        rd_eoi[1] && !hit_zero[1] |=> !st_r.flag[1] && RDATA == 32'h0)
        else $error("eoi read did not clear or returned nonzero");

    a_eoi2_clear: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        rd_eoi[0] && !hit_zero[0] |=> !st_r.flag[0]
            && $stable(st_r.flag[1]) || hit_zero[1])
        else $error("channel two eoi misbehaved");

    a_eoi_zero2: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        rd_eoi[0] |=> RDATA == 32'h0)
        else $error("channel two eoi read returned nonzero");

    a_eoi_other: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        rd_eoi[1] && !hit_zero[0] |=> $stable(st_r.flag[0]))
        else $error("channel three eoi touched channel two");

    a_status_read: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        RD && ADDR == dctr_pkg::CH3_FLAG
        |=> RDATA == {31'h0, $past(st_r.flag[1])})
        else $error("status read wrong");

    a_status2_read: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        RD && ADDR == dctr_pkg::CH2_FLAG
        |=> RDATA == {31'h0, $past(st_r.flag[0])})
        else $error("channel two status read wrong");

    a_live_read2: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        RD && ADDR == dctr_pkg::CH2_LIVE
        |=> RDATA == {8'h00, $past(st_r.count[0])})
        else $error("live count read wrong");

    a_reload_read3: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        RD && ADDR == dctr_pkg::CH3_RELOAD
        |=> RDATA == {8'h00, $past(st_r.reload[1])})
        else $error("channel three reload read wrong");

    // Read data must not linger, software may poll back to back
    a_rdata_idle: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        !RD |=> RDATA == 32'h0)
        else $error("read data outside its cycle");

    a_tick_rate: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        tick |=> s_tick_gap)
        else $error("tick period wrong");

    a_irq_level: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        IRQ == |(st_r.stat & st_r.mask))
        else $error("interrupt line disagrees with status");

    a_stat_clear2: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        WR && ADDR == dctr_pkg::IRQ_STAT && WDATA[0] && !hit_zero[0]
        |=> !st_r.stat[0])
        else $error("status write one did not clear");

    a_mask_wr: assert property (
        @(posedge REF_CLK) disable iff (!RST_N)
        WR && ADDR == dctr_pkg::IRQ_MASK
        |=> st_r.mask == $past(WDATA[dctr_pkg::NCH-1:0]))
        else $error("interrupt mask not stored");

endmodule // dctr_top

/* shared/dctr_pkg.sv */
// Constants for the dual countdown timer register block
// Assumes a byte-addressed register port with 32-bit data
package dctr_pkg;
    localparam int          ADDR_W      = 8;
    localparam int          CNT_W       = 24;
    localparam int          DATA_W      = 32;
    localparam int          NCH         = 2;
    // Channel register offsets
    localparam logic [7:0]  CH2_RELOAD  = 8'h14;
    localparam logic [7:0]  CH2_LIVE    = 8'h18;
    localparam logic [7:0]  CH2_CTRL    = 8'h1c;
    localparam logic [7:0]  CH2_EOI     = 8'h20;
    localparam logic [7:0]  CH2_FLAG    = 8'h24;
    localparam logic [7:0]  CH3_RELOAD  = 8'h28;
    localparam logic [7:0]  CH3_LIVE    = 8'h2c;
    localparam logic [7:0]  CH3_CTRL    = 8'h30;
    localparam logic [7:0]  CH3_EOI     = 8'h34;
    localparam logic [7:0]  CH3_FLAG    = 8'h38;
    // Block-level sticky status and mask
    localparam logic [7:0]  IRQ_STAT    = 8'h48;
    localparam logic [7:0]  IRQ_MASK    = 8'h4c;
    // Control fields
    localparam int          CTL_EN      = 0;
    localparam int          CTL_MODE    = 1;
    localparam int          CTL_MSK     = 2;
    localparam int          CTL_W       = 3;
    localparam logic [23:0] CNT_RST     = 24'h000000;
    localparam logic [23:0] CNT_MAX     = 24'hffffff;
    localparam logic [2:0]  CTL_RST     = 3'h0;
    // Timer tick: 4 MHz from 100 MHz
    localparam int          REF_HZ      = 100000000;
    localparam int          TICK_HZ     = 4000000;
    localparam int          TICK_DIV    = REF_HZ / TICK_HZ;
    localparam logic [4:0]  TICK_LAST   = 5'(TICK_DIV - 1);
endpackage

/* test/dual_countdown_timer_regs_bench.sv */
// Self-checking bench for the dual countdown timer register block
// Assumes dctr_pkg is compiled first; the bench drives every input port itself
`timescale 1ns/100ps

module dual_countdown_timer_regs_bench;
    logic        ref_clk = 1'b0;
    logic        rst_n   = 1'b0;
    logic [7:0]  addr    = 8'h00;
    logic [31:0] wdata   = 32'h0;
    logic        wr      = 1'b0;
    logic        rd      = 1'b0;
    logic [31:0] rdata;
    logic        irq;
    int          n_mismatch = 0;
    int          tests_run  = 0;
    logic [31:0] v;

    dctr_top dut (.REF_CLK(ref_clk), .RST_N(rst_n), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .IRQ(irq));

    initial begin
        forever #5 ref_clk = ~ref_clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        wr <= 1'b1; addr <= a; wdata <= d;
        @(posedge ref_clk);
        wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        rd <= 1'b1; addr <= a;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1 v = rdata;
        chk(v, exp);
    endtask
    task automatic complete_run;
        $display("mismatches %0d of %0d checks", n_mismatch, tests_run);
        if (n_mismatch == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        for (int a = 8'h14; a <= 8'h38; a += 4) rd_chk(8'(a), 32'h0);
        rd_chk(8'h3c, 32'h0);
    endtask
    task automatic t_access;
        wr_reg(dctr_pkg::CH2_RELOAD, 32'hffffffff);
        rd_chk(dctr_pkg::CH2_RELOAD, 32'h00ffffff);
        wr_reg(dctr_pkg::CH2_LIVE, 32'h00123456);
        rd_chk(dctr_pkg::CH2_LIVE, 32'h0);
        wr_reg(dctr_pkg::CH3_CTRL, 32'hfffffff4);
        rd_chk(dctr_pkg::CH3_CTRL, 32'h4);
        wr_reg(dctr_pkg::CH3_CTRL, 32'h0);
    endtask
    // Clear from the third channel must leave the second pending
    task automatic t_user;
        wr_reg(dctr_pkg::CH2_RELOAD, 32'h2);
        wr_reg(dctr_pkg::IRQ_MASK, 32'h3);
        wr_reg(dctr_pkg::CH2_CTRL, 32'h3);
        rd_chk(dctr_pkg::CH2_LIVE, 32'h2);
        repeat (100) @(posedge ref_clk);
        rd_chk(dctr_pkg::CH2_FLAG, 32'h1);
        chk({31'h0, irq}, 32'h1);
        rd_chk(dctr_pkg::CH3_EOI, 32'h0);
        rd_chk(dctr_pkg::CH2_FLAG, 32'h1);
        wr_reg(dctr_pkg::CH2_CTRL, 32'h0);
        rd_chk(dctr_pkg::CH2_EOI, 32'h0);
        rd_chk(dctr_pkg::CH2_FLAG, 32'h0);
        rd_chk(dctr_pkg::CH2_CTRL, 32'h0);
        wr_reg(dctr_pkg::IRQ_STAT, 32'h3);
        repeat (2) @(posedge ref_clk);
        #1 chk({31'h0, irq}, 32'h0);
    endtask
    task automatic t_mask;
        wr_reg(dctr_pkg::CH3_RELOAD, 32'h1);
        wr_reg(dctr_pkg::CH3_CTRL, 32'h7);
        repeat (100) @(posedge ref_clk);
        rd_chk(dctr_pkg::CH3_FLAG, 32'h0);
        chk({31'h0, irq}, 32'h0);
        wr_reg(dctr_pkg::CH3_CTRL, 32'h0);
    endtask
    // Four ticks: 1 to 0, wrap to all ones, then two decrements
    task automatic t_free;
        wr_reg(dctr_pkg::CH3_CTRL, 32'h1);
        repeat (78) @(posedge ref_clk);
        wr_reg(dctr_pkg::CH3_CTRL, 32'h0);
        #1 chk({31'h0, irq}, 32'h1);
        rd_chk(dctr_pkg::CH3_LIVE, 32'h00fffffd);
        rd_chk(dctr_pkg::CH3_FLAG, 32'h1);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        #200000;
        n_mismatch++;
        complete_run();
    end
    initial begin
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        t_reset();
        t_access();
        t_user();
        t_mask();
        t_free();
        complete_run();
    end
endmodule // dual_countdown_timer_regs_bench
